// ### hw/mem_clk_ctrl.sv
/*
 * Memory-clock delay-line control and bus hold-delay configuration block.
 * Holds the configuration registers, the strap capture, the tap tracker and the hold delay.
 * Assumes straps are stable around reset release and all inputs are synchronous to i_mclk.
 */
`timescale 1ns/1ps

// What this block does
// - Two bits choose one of four modes
// - 128 taps; max spacing lengthens taps
// - Tap position readable at 0xE3 bits 6-0
// - Tap value follows live position when locked
// - Inverted straps seed hold field at reset
// - Undriven pulled-up straps give hold 0b00
// - Software rewrites hold; applied to bus
// - Hold change shifts hold and valid
// - Memory clock 1:1 or doubled at 2:1
// - Core rate from reference and strap
// - PLL strap bits 3-0 readable at 0xE2 bits 7-4
module mem_clk_ctrl
    import clk_dll_pkg::*;
#(
    parameter int TAPS = TAP_COUNT
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Reset configuration straps.
    input wire logic i_hold_strap_high,
    input wire logic i_hold_strap_low,
    input wire logic [4:0] i_pll_strap,
    input wire logic i_mem_2to1,
    // Phase comparator from the clock feedback loop.
    input wire logic i_phase_late,
    input wire logic i_phase_early,
    // Bused output launch strobe.
    input wire logic i_bus_launch,
    // Derived controls.
    output logic o_bus_launch,
    output logic [1:0] o_bus_output_hold_setting,
    output logic o_max_spacing,
    output logic o_loop_extend,
    output logic o_dll_locked,
    output logic o_mem_clk_double,
    output logic [4:0] o_core_ratio_sel
);

    // The tap field is seven bits; other depths cannot be shown.
    if (TAPS != 128)
    begin : g_chk
        $error("mem_clk_ctrl supports 128 taps only");
    end

    // Bundled register request.
    reg_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Configuration registers and strap captures.
    logic [7:0] cfg2_q, cfg2_d;
    logic [7:0] spacing_q, spacing_d;
    logic [4:0] pll_q, pll_d;
    logic mem2_q, mem2_d;
    logic seeded_q, seeded_d;
    logic [7:0] rdata_q, rdata_d;

    // Tracker status.
    dll_stat_t stat;
    dll_mode_t mode;

    // Returns true when the request addresses a given offset.
    function automatic logic hit(input reg_req_t r, input logic [7:0] off);
        hit = (r.addr == off);
    endfunction

    // Mode from the two configuration bits.
    assign mode = dll_mode_t'({spacing_q[BIT_MAX_SPACING], cfg2_q[BIT_LOOP_EXTEND]});

    // Tap tracker on the feedback loop.
    dll_tap_tracker #(
        .TAPS(TAPS)
    ) i_dll_tap_tracker (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_mode(mode),
        .i_phase_late(i_phase_late),
        .i_phase_early(i_phase_early),
        .o_stat(stat)
    );

    // Hold delay applied to the bused output launch.
    pci_hold_delay i_pci_hold_delay (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_setting(cfg2_q[BIT_HOLD_HI:BIT_HOLD_LO]),
        .i_launch(i_bus_launch),
        .o_launch(o_bus_launch)
    );

    // Next register values: strap seeding once after release, then software writes.
    always_comb
    begin
        cfg2_d = cfg2_q;
        spacing_d = spacing_q;
        pll_d = pll_q;
        mem2_d = mem2_q;
        seeded_d = 1'b1;
        if (!seeded_q)
        begin
            // Straps are inverted into the hold field; pulled-up straps yield zero.
            cfg2_d[BIT_HOLD_HI] = ~i_hold_strap_high;
            cfg2_d[BIT_HOLD_LO] = ~i_hold_strap_low;
            pll_d = i_pll_strap;
            mem2_d = i_mem_2to1;
        end
        else if (req.wr)
        begin
            if (hit(req, OFF_PWR_CFG2))
            begin
                cfg2_d = req.wdata;
            end
            else if (hit(req, OFF_TAP_SPACING))
            begin
                spacing_d = req.wdata;
            end
            // Writes to the tap, strap, status or unmapped offsets are dropped.
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    always_comb
    begin
        rdata_d = 8'h00;
        if (req.rd)
        begin
            if (hit(req, OFF_PWR_CFG2))
            begin
                rdata_d = cfg2_q;
            end
            else if (hit(req, OFF_TAP_SPACING))
            begin
                rdata_d = spacing_q;
            end
            else if (hit(req, OFF_PLL_STRAP))
            begin
                rdata_d = {pll_q[3:0], 4'h0};
            end
            else if (hit(req, OFF_TAP_POS))
            begin
                // Live tap once locked, zero before; reading has no effect.
                rdata_d = stat.locked ? {1'b0, stat.tap} : 8'h00;
            end
            else if (hit(req, OFF_DLL_STATUS))
            begin
                rdata_d = {7'h00, stat.locked};
            end
        end
    end

    // Registers all configuration state.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg2_q <= RST_PWR_CFG2;
            spacing_q <= RST_TAP_SPACING;
            pll_q <= 5'h00;
            mem2_q <= 1'b0;
            seeded_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            cfg2_q <= cfg2_d;
            spacing_q <= spacing_d;
            pll_q <= pll_d;
            mem2_q <= mem2_d;
            seeded_q <= seeded_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs, all from flip-flops.
    assign o_rdata = rdata_q;
    assign o_bus_output_hold_setting = cfg2_q[BIT_HOLD_HI:BIT_HOLD_LO];
    assign o_max_spacing = spacing_q[BIT_MAX_SPACING];
    assign o_loop_extend = cfg2_q[BIT_LOOP_EXTEND];
    assign o_dll_locked = stat.locked;
    assign o_mem_clk_double = mem2_q;
    assign o_core_ratio_sel = pll_q;

    // Hold field carries the inverted straps one cycle after release.
    strap_seed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !seeded_q |=> cfg2_q[5:4] == ~$past({i_hold_strap_high, i_hold_strap_low}))
        else $error("hold field not seeded from inverted straps");

    // High straps give a zero hold field.
    strap_high_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!seeded_q && i_hold_strap_high && i_hold_strap_low) |=> cfg2_q[5:4] == 2'h0)
        else $error("pulled-up straps did not yield zero hold");

    // A write to the config register reaches the hold output next cycle.
    hold_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (seeded_q && i_wr && i_addr == OFF_PWR_CFG2) |=> o_bus_output_hold_setting == $past(i_wdata[5:4]))
        else $error("hold write not applied");

    // A write to the config register reaches the loop extend output next cycle.
    ext_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (seeded_q && i_wr && i_addr == OFF_PWR_CFG2) |=> o_loop_extend == $past(i_wdata[7]))
        else $error("loop extend write not applied");

    // The max spacing mode bit follows writes to the tap spacing register.
    mode_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (seeded_q && i_wr && i_addr == OFF_TAP_SPACING) |=> o_max_spacing == $past(i_wdata[2]))
        else $error("tap spacing write not applied");

    // Tap read returns the locked live tap one cycle later.
    tap_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFF_TAP_POS && stat.locked) |=> o_rdata == {1'b0, $past(stat.tap)})
        else $error("tap read mismatch");

    // Writes to the tap register change no configuration.
    tap_nowrite_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (seeded_q && i_wr && i_addr == OFF_TAP_POS) |=> $stable(cfg2_q) && $stable(spacing_q))
        else $error("tap register write had an effect");

    // Strap read shows the low four captured strap bits in the high nibble.
    strap_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFF_PLL_STRAP) |=> o_rdata == {$past(pll_q[3:0]), 4'h0})
        else $error("strap read mismatch");

    // Read data is zero when no read was made.
    idle_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data without read strobe");

endmodule

// ### hw/clk_dll_pkg.sv
/*
 * Package for the memory-clock delay-line control and bus hold-delay block.
 * Holds register offsets, field positions, reset values, timing counts and carrier types.
 * Assumes an 8-bit configuration space reached over a plain strobe port.
 */
package clk_dll_pkg;

    // Register offsets in the configuration space.
    localparam logic [7:0] OFF_PWR_CFG2 = 8'h72;
    localparam logic [7:0] OFF_TAP_SPACING = 8'h76;
    localparam logic [7:0] OFF_PLL_STRAP = 8'he2;
    localparam logic [7:0] OFF_TAP_POS = 8'he3;
    localparam logic [7:0] OFF_DLL_STATUS = 8'hf0;

    // Field positions.
    localparam int BIT_LOOP_EXTEND = 7;
    localparam int BIT_HOLD_HI = 5;
    localparam int BIT_HOLD_LO = 4;
    localparam int BIT_MAX_SPACING = 2;
    localparam int BIT_STRAP_LSB = 4;

    // Reset values of the writable registers, hold field excluded.
    localparam logic [7:0] RST_PWR_CFG2 = 8'h00;
    localparam logic [7:0] RST_TAP_SPACING = 8'h00;

    // Delay line geometry.
    localparam int TAP_COUNT = 128;
    localparam logic [6:0] TAP_MAX = 7'h7f;
    localparam logic [6:0] TAP_LOW_LIMIT = 7'h0c;

    // Phase comparator settle time and derived cycle count at 200 MHz.
    localparam int SETTLE_NS = 40;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_STABLE = 4;

    // The four delay-line modes.
    typedef enum logic [1:0]
    {
        MODE_NORM_NOEXT = 2'h0,
        MODE_NORM_EXT = 2'h1,
        MODE_MAX_NOEXT = 2'h2,
        MODE_MAX_EXT = 2'h3
    } dll_mode_t;

    // Software bus request.
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Delay-line status carried to the register file.
    typedef struct packed
    {
        logic locked;
        logic [6:0] tap;
    } dll_stat_t;

endpackage

// ### hw/dll_tap_tracker.sv
/*
 * Delay-line tap tracker: steps the tap point toward the phase reference and flags lock.
 * Assumes the phase comparator outputs are synchronous to i_mclk.
 */
`timescale 1ns/1ps
module dll_tap_tracker
    import clk_dll_pkg::*;
#(
    parameter int TAPS = TAP_COUNT
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Mode and phase comparator.
    input wire dll_mode_t i_mode,
    input wire logic i_phase_late,
    input wire logic i_phase_early,
    // Status.
    output dll_stat_t o_stat
);

    // The tap register is seven bits wide, so only 128 taps fit.
    if (TAPS != 128)
    begin : g_chk
        $error("dll_tap_tracker supports 128 taps only");
    end

    // Current tap, settle counter, and stable-lock counter.
    logic [6:0] tap_q, tap_d;
    logic [3:0] settle_q, settle_d;
    logic [2:0] stab_q, stab_d;
    logic locked_q, locked_d;
    dll_mode_t mode_q, mode_d;

    // Steps the tap once per settle window; a mode change relocks from zero.
    always_comb
    begin
        tap_d = tap_q;
        settle_d = settle_q;
        stab_d = stab_q;
        locked_d = locked_q;
        mode_d = i_mode;
        if (i_mode != mode_q)
        begin
            tap_d = 7'h00;
            settle_d = 4'h0;
            stab_d = 3'h0;
            locked_d = 1'b0;
        end
        else if (settle_q != 4'(SETTLE_CYC - 1))
        begin
            settle_d = settle_q + 4'h1;
        end
        else
        begin
            settle_d = 4'h0;
            if (i_phase_late && tap_q != TAP_MAX)
            begin
                tap_d = tap_q + 7'h01;
            end
            else if (i_phase_early && tap_q != 7'h00)
            begin
                tap_d = tap_q - 7'h01;
            end
            if (i_phase_late == i_phase_early)
            begin
                if (stab_q != 3'(LOCK_STABLE))
                begin
                    stab_d = stab_q + 3'h1;
                end
            end
            else if (!locked_q)
            begin
                stab_d = 3'h0;
            end
            locked_d = locked_q || (stab_d == 3'(LOCK_STABLE));
        end
    end

    // Registers the tracker state.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tap_q <= 7'h00;
            settle_q <= 4'h0;
            stab_q <= 3'h0;
            locked_q <= 1'b0;
            mode_q <= MODE_NORM_NOEXT;
        end
        else
        begin
            tap_q <= tap_d;
            settle_q <= settle_d;
            stab_q <= stab_d;
            locked_q <= locked_d;
            mode_q <= mode_d;
        end
    end

    assign o_stat = '{locked: locked_q, tap: tap_q};

    // A tap moves by at most one step per cycle.
    tap_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_mode == mode_q) |=> (tap_q == $past(tap_q) || tap_q == $past(tap_q) + 7'h01
            || tap_q == $past(tap_q) - 7'h01))
        else $error("tap jumped by more than one step");

endmodule

// ### hw/pci_hold_delay.sv
/*
 * Bus output hold-delay selector: delays the launch strobe of bused outputs by the setting.
 * Assumes the launch strobe is a one-cycle pulse on i_mclk.
 */
`timescale 1ns/1ps
module pci_hold_delay
    import clk_dll_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Setting and launch.
    input wire logic [1:0] i_setting,
    input wire logic i_launch,
    // Delayed launch.
    output logic o_launch
);

    // Delay chain of three stages; the setting picks zero to three cycles.
    logic [2:0] chain_q, chain_d;

    // Shifts the launch strobe along the chain.
    always_comb
    begin
        chain_d = {chain_q[1:0], i_launch};
    end

    // Registers the chain.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            chain_q <= 3'h0;
        end
        else
        begin
            chain_q <= chain_d;
        end
    end

    // Both hold and output-valid move together since one strobe launches the output.
    assign o_launch = (i_setting == 2'h0) ? i_launch : chain_q[i_setting - 2'h1];

    // A launch shows after exactly the chosen delay of two.
    hold_two_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_setting == 2'h2 && i_launch) ##2 (i_setting == 2'h2) |-> o_launch)
        else $error("hold delay of two cycles not applied");

endmodule

// ### sim/fb_loop_model.sv
/*
 * Model of the memory clock feedback loop that drives the phase comparator inputs.
 * Assumes the tap restarts at zero after a mode change and steps once per settle window.
 */
`timescale 1ns/1ps
module fb_loop_model
    import clk_dll_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Control from the bench.
    input wire logic i_restart,
    input wire logic [6:0] i_target,
    // Phase comparator outputs.
    output logic o_phase_late,
    output logic o_phase_early
);
    // Cycles still reported late before the loop is aligned.
    int unsigned left_q;

    // Reload on restart, then count down one settle window per tap.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            left_q <= 0;
        end
        else if (i_restart)
        begin
            left_q <= i_target * SETTLE_CYC;
        end
        else if (left_q != 0)
        begin
            left_q <= left_q - 1;
        end
    end

    // The line is short of the loop until the count runs out; it never overshoots.
    assign o_phase_late = (left_q != 0);
    assign o_phase_early = 1'b0;
endmodule

// ### sim/mem_clk_ctrl_test.sv
/*
 * Self-checking bench for the delay-line control and bus hold-delay block.
 * Assumes a 200 MHz clock and the feedback loop model on the phase inputs.
 */
`timescale 1ns/1ps
module mem_clk_ctrl_test;
    import clk_dll_pkg::*;

    // Stimulus and observed signals.
    logic mclk = 0;
    logic rst_n = 0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 0;
    logic rd = 0;
    logic [7:0] rdata;
    logic strap_hi = 1;
    logic strap_lo = 1;
    logic [4:0] pll = 5'h15;
    logic m2 = 1;
    logic late;
    logic early;
    logic launch = 0;
    logic launch_o;
    logic [1:0] hold;
    logic maxsp;
    logic ext;
    logic locked;
    logic dbl;
    logic [4:0] ratio;
    logic restart = 0;
    logic [6:0] target = 7'h14;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    // The clock toggles every half period.
    always #2.5 mclk = ~mclk;

    mem_clk_ctrl i_mem_clk_ctrl (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_hold_strap_high(strap_hi), .i_hold_strap_low(strap_lo),
        .i_pll_strap(pll), .i_mem_2to1(m2), .i_phase_late(late), .i_phase_early(early),
        .i_bus_launch(launch), .o_bus_launch(launch_o), .o_bus_output_hold_setting(hold),
        .o_max_spacing(maxsp), .o_loop_extend(ext), .o_dll_locked(locked), .o_mem_clk_double(dbl),
        .o_core_ratio_sel(ratio));

    fb_loop_model i_fb_loop_model (.i_mclk(mclk), .i_rst_n(rst_n), .i_restart(restart),
        .i_target(target), .o_phase_late(late), .o_phase_early(early));

    // Prints the counts and the verdict, then stops.
    task report_and_stop();
        $display("mismatches=%0d comparisons=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    // Compares one result byte.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle register write.
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge mclk);
        wr <= 0;
        // Let the write edge settle so callers see the new register value.
        #1;
    endtask

    // One-cycle register read; data is taken in the following cycle only.
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1;
        @(posedge mclk);
        rd <= 0;
        #1;
        d = rdata;
    endtask

    // Applies reset with the given hold straps, then skips the seeding edge.
    task do_reset(input logic h, input logic l);
        strap_hi <= h;
        strap_lo <= l;
        rst_n <= 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        repeat (2) @(posedge mclk);
    endtask

    // Values out of reset with the straps left at their pulled-up level.
    task t_reset_values();
        logic [7:0] d;
        chk({6'h0, hold}, 8'h00);
        rd_reg(OFF_PWR_CFG2, d);
        chk(d, 8'h00);
        rd_reg(OFF_TAP_SPACING, d);
        chk(d, RST_TAP_SPACING);
        rd_reg(OFF_PLL_STRAP, d);
        chk(d, {pll[3:0], 4'h0});
        chk({3'h0, ratio}, {3'h0, pll});
        chk({7'h0, dbl}, {7'h0, m2});
    endtask

    // Each strap level is inverted into the hold field.
    task t_strap_seed();
        logic [7:0] d;
        do_reset(1'b0, 1'b1);
        chk({6'h0, hold}, 8'h02);
        rd_reg(OFF_PWR_CFG2, d);
        chk(d, 8'h20);
        // The 1:1 ratio strap and another PLL strap are captured by this reset.
        m2 <= 1'b0;
        pll <= 5'h0a;
        do_reset(1'b1, 1'b0);
        chk({6'h0, hold}, 8'h01);
        chk({7'h0, dbl}, 8'h00);
        chk({3'h0, ratio}, 8'h0a);
        rd_reg(OFF_PLL_STRAP, d);
        chk(d, 8'ha0);
        m2 <= 1'b1;
        do_reset(1'b1, 1'b1);
    endtask

    // All four delay-line modes are set and read back.
    task t_modes();
        logic [7:0] d;
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(OFF_TAP_SPACING, {5'h0, m[1], 2'h0});
            wr_reg(OFF_PWR_CFG2, {m[0], 7'h0});
            chk({6'h0, maxsp, ext}, m[7:0]);
            rd_reg(OFF_TAP_SPACING, d);
            chk(d, {5'h0, m[1], 2'h0});
        end
    endtask

    // Each hold setting is written and delays the launch strobe by that many cycles.
    task t_hold();
        int first;
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(OFF_PWR_CFG2, {2'h0, s[1:0], 4'h0});
            chk({6'h0, hold}, s[7:0]);
            first = 9;
            @(posedge mclk);
            launch <= 1;
            for (int k = 0; k < 6; k++)
            begin
                #1;
                if (launch_o === 1'b1 && first == 9)
                    first = k;
                @(posedge mclk);
                launch <= 0;
            end
            chk(first[7:0], s[7:0]);
        end
    endtask

    // Lock on a loop, read the tap, and try to overwrite it.
    task t_lock();
        logic [7:0] d;
        logic [7:0] tap;
        int k;
        // Software tries the extended mode on this loop and keeps its low count.
        wr_reg(OFF_PWR_CFG2, 8'h80);
        @(posedge mclk);
        restart <= 1;
        @(posedge mclk);
        restart <= 0;
        rd_reg(OFF_TAP_POS, d);
        chk(d, 8'h00);
        for (k = 0; k < 600 && locked !== 1'b1; k++)
            @(posedge mclk);
        chk({7'h0, locked}, 8'h01);
        rd_reg(OFF_DLL_STATUS, d);
        chk(d, 8'h01);
        rd_reg(OFF_TAP_POS, tap);
        chk({7'h0, tap[7]}, 8'h00);
        chk({7'h0, (tap + 8'h2 >= {1'b0, target}) && (tap <= {1'b0, target} + 8'h2)}, 8'h01);
        wr_reg(OFF_TAP_POS, 8'h55);
        rd_reg(OFF_TAP_POS, d);
        chk(d, tap);
        chk({7'h0, locked}, 8'h01);
        rd_reg(8'h40, d);
        chk(d, 8'h00);
    endtask

    // Main sequence.
    initial
    begin
        do_reset(1'b1, 1'b1);
        t_reset_values();
        t_strap_seed();
        t_modes();
        t_hold();
        t_lock();
        report_and_stop();
    end
endmodule
